/* common/dcmp_defs.svh */
// register offsets, field positions, reset values and mode codes for the dual comparator
// assumes a byte-addressed APB with 32-bit data; registers sit in the low byte of each word
`ifndef DCMP_DEFS_SVH
`define DCMP_DEFS_SVH

`define DCMP_OFS_CTRL       12'h000
`define DCMP_OFS_IRQ        12'h004
`define DCMP_OFS_PORTA      12'h008
`define DCMP_OFS_DIR        12'h00c
`define DCMP_OFS_ACFG       12'h010

`define DCMP_CTRL_RESET     8'h07
`define DCMP_MODE_OFF       3'h7
`define DCMP_MODE_MUX4      3'h6
`define DCMP_MODE_OUTS      3'h5
`define DCMP_DIR_RESET      6'h3f
`define DCMP_ACFG_RESET     4'hf

`define DCMP_BIT_CMP2_RES   7
`define DCMP_BIT_CMP1_RES   6
`define DCMP_BIT_CMP2_INV   5
`define DCMP_BIT_CMP1_INV   4
`define DCMP_BIT_INSW       3
`define DCMP_BIT_FLAG       0
`define DCMP_BIT_EN_CMP     1
`define DCMP_BIT_EN_PERIPH  2
`define DCMP_BIT_EN_GLOBAL  3

`endif

/* common/dcmp_pkg.sv */
// types shared by the dual comparator control block
// assumes dcmp_defs.svh supplies the numeric constants
package dcmp_pkg;

  typedef struct packed {
    logic [1:0] invert;
    logic       in_sw;
    logic [2:0] mode;
  } dcmp_ctrl_s;

  typedef struct packed {
    dcmp_ctrl_s ctrl;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] latched;
    logic       flag;
    logic       cmp_en;
    logic       periph_en;
    logic       global_en;
    logic [5:0] dir;
    logic [3:0] acfg;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_s3;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
    logic       irq;
    logic       wake;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n;
    logic [1:0] vneg_sel;
    logic       vref_on;
  } dcmp_state_s;

endpackage : dcmp_pkg

/* rtl/dcmp_top.sv */
// dual comparator control: control register, result readback, change flag, pin routing
// assumes raw comparator outputs and port pins are asynchronous; APB master on mclk
`timescale 1ns/1ps
`include "dcmp_defs.svh"

module dcmp_top
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // analog side
  input  wire logic [1:0]  cmp_raw,
  input  wire logic [5:0]  porta_pin_in,
  output logic [1:0]       vneg_sel,
  output logic             vref_on,
  // pins 4 and 5
  output logic [1:0]       pin45_out,
  output logic [1:0]       pin45_oe_n,
  // system
  output logic             irq,
  output logic             wake
);

  dcmp_pkg::dcmp_state_s s_q;
  dcmp_pkg::dcmp_state_s s_d;

  logic [1:0] cmp_res;
  logic [1:0] pin_drv;
  logic       acc;
  logic       wr;
  logic [5:0] analog_mask;

  // true when the port pin is an analog input under the pin config
  function automatic logic [5:0] analog_pins(input logic [3:0] cfg);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 5; i++)
    begin
      if (4'(i) < (4'hf - cfg))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : analog_pins

  // true when the byte address hits one of the five registers
  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == `DCMP_OFS_CTRL) || (a == `DCMP_OFS_IRQ) || (a == `DCMP_OFS_PORTA) ||
           (a == `DCMP_OFS_DIR) || (a == `DCMP_OFS_ACFG);
  endfunction : addr_mapped

  assign cmp_res     = s_q.sync2 ^ s_q.ctrl.invert;
  assign acc         = psel && penable && !s_q.pready;
  // writes land at the edge that samples pready high, so a master never sees one early
  assign wr          = psel && penable && pwrite && s_q.pready;
  assign analog_mask = analog_pins(s_q.acfg);
  // pin path takes the raw comparator output: no sync delay on purpose
  assign pin_drv     = cmp_raw ^ s_q.ctrl.invert;

  always_comb
  begin
    s_d         = s_q;
    s_d.sync1   = cmp_raw;
    s_d.sync2   = s_q.sync1;
    s_d.pin_s1  = porta_pin_in;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.pin_s3  = s_q.pin_s2;
    s_d.pready  = acc;
    s_d.pslverr = acc && !addr_mapped(paddr);
    s_d.prdata  = 32'h0000_0000;

    if ((acc && !pwrite) || wr)
    begin
      case (paddr)
        `DCMP_OFS_CTRL:
        begin
          s_d.latched = cmp_res;
          if (pwrite)
          begin
            s_d.ctrl.invert = pwdata[`DCMP_BIT_CMP2_INV:`DCMP_BIT_CMP1_INV];
            s_d.ctrl.in_sw  = pwdata[`DCMP_BIT_INSW];
            s_d.ctrl.mode   = pwdata[2:0];
          end
          else
          begin
            s_d.prdata[7:0] = {cmp_res, s_q.ctrl};
          end
        end
        `DCMP_OFS_IRQ:
        begin
          if (pwrite)
          begin
            s_d.flag = pwdata[`DCMP_BIT_FLAG];
            s_d.cmp_en    = pwdata[`DCMP_BIT_EN_CMP];
            s_d.periph_en = pwdata[`DCMP_BIT_EN_PERIPH];
            s_d.global_en = pwdata[`DCMP_BIT_EN_GLOBAL];
          end
          else
          begin
            s_d.prdata[3:0] = {s_q.global_en, s_q.periph_en, s_q.cmp_en, s_q.flag};
          end
        end
        `DCMP_OFS_PORTA:
        begin
          if (!pwrite)
          begin
            // a pin reads high only once the second and third stages are both high
            s_d.prdata[5:0] = s_q.pin_s2 & s_q.pin_s3 & ~analog_mask;
          end
        end
        `DCMP_OFS_DIR:
        begin
          if (pwrite)
          begin
            s_d.dir = pwdata[5:0];
          end
          else
          begin
            s_d.prdata[5:0] = s_q.dir;
          end
        end
        `DCMP_OFS_ACFG:
        begin
          if (pwrite)
          begin
            s_d.acfg = pwdata[3:0];
          end
          else
          begin
            s_d.prdata[3:0] = s_q.acfg;
          end
        end
        default:
        begin
          s_d.prdata = 32'h0000_0000;
        end
      endcase
    end

    // mismatch sets the flag after any clear in the same cycle; a control access
    // compares against the freshly latched value so a same-cycle change is missed
    if ((cmp_res != s_d.latched) && (s_q.ctrl.mode != `DCMP_MODE_OFF))
    begin
      s_d.flag = 1'b1;
    end

    s_d.irq  = s_d.flag && s_d.cmp_en && s_d.periph_en && s_d.global_en;
    // wake uses no clock-gated path here; it reflects the enabled flag in sleep too
    s_d.wake = s_d.flag && s_d.cmp_en;

    s_d.vref_on  = (s_d.ctrl.mode == `DCMP_MODE_MUX4);
    s_d.vneg_sel = (s_d.ctrl.mode == `DCMP_MODE_MUX4) ? {2{s_d.ctrl.in_sw}} : 2'b00;
    if (s_d.ctrl.mode == `DCMP_MODE_OUTS)
    begin
      s_d.pin_out = pin_drv;
    end
    else
    begin
      s_d.pin_out = 2'b00;
    end
    s_d.pin_oe_n = s_d.dir[5:4];

    if (!rst_n)
    begin
      s_d          = '0;
      s_d.ctrl     = dcmp_pkg::dcmp_ctrl_s'(6'(`DCMP_CTRL_RESET));
      s_d.dir      = `DCMP_DIR_RESET;
      s_d.acfg     = `DCMP_ACFG_RESET;
      s_d.pin_oe_n = 2'b11;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign pready     = s_q.pready;
  assign prdata     = s_q.prdata;
  assign pslverr    = s_q.pslverr;
  assign irq        = s_q.irq;
  assign wake       = s_q.wake;
  assign pin45_out  = s_q.pin_out;
  assign pin45_oe_n = s_q.pin_oe_n;
  assign vneg_sel   = s_q.vneg_sel;
  assign vref_on    = s_q.vref_on;

endmodule : dcmp_top

/* tb/dcmp_assertions.sv */
// port checks for the dual comparator control block
// assumes it is bound onto dcmp_top; one clock, synchronous reset
`timescale 1ns/1ps
module dcmp_assertions
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // outputs
  input wire logic [1:0]  vneg_sel,
  input wire logic        vref_on,
  input wire logic [1:0]  pin45_out,
  input wire logic [1:0]  pin45_oe_n,
  input wire logic        irq,
  input wire logic        wake
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    psel && $rose(penable);
  endsequence
  property p_rst; $rose(rst_n) |-> pin45_oe_n == 2'b11 && !irq && !vref_on; endproperty
  property p_ans; s_take |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && (paddr > 12'h010 || paddr[1:0] != 2'b00); endproperty
  property p_hi; pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h00_0000; endproperty
  property p_ref; vneg_sel != 2'b00 |-> vref_on; endproperty
  property p_pin; pin45_out != 2'b00 |-> !vref_on; endproperty
  property p_irq; irq |-> wake; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("pready too long");
  a_err: assert property (p_err) else $error("bad pslverr");
  a_hi: assert property (p_hi) else $error("ctrl upper bits set");
  a_ref: assert property (p_ref) else $error("switch outside mode 6");
  a_pin: assert property (p_pin) else $error("pins driven in mode 6");
  a_irq: assert property (p_irq) else $error("irq without flag");
endmodule : dcmp_assertions
bind dcmp_top dcmp_assertions dcmp_assertions_inst (.*);

/* tb/dcmp_ana_model.sv */
// analog side stand-in: the two comparators
// assumes the bench sets input voltages as 8-bit codes
`timescale 1ns/1ps
module dcmp_ana_model
(
  // voltages per comparator
  input  wire logic [1:0][7:0] vin_p,
  input  wire logic [1:0][7:0] vin_n,
  // to the block
  output logic      [1:0]      cmp_raw
);
  // a tie reads low, as a real comparator would be unsure there
  assign cmp_raw = {vin_p[1] > vin_n[1], vin_p[0] > vin_n[0]};
endmodule : dcmp_ana_model

/* tb/dcmp_top_tb_top.sv */
// self-checking bench for the dual comparator control block
// assumes the checker binds itself; apb master lives here
`timescale 1ns/1ps
module dcmp_top_tb_top;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [1:0][7:0] vin_p = '0, vin_n = '0;
  logic [5:0]  porta_pin_in = 6'h3f;
  logic [1:0]  cmp_raw, vneg_sel, pin45_out, pin45_oe_n;
  logic        pready, pslverr, vref_on, irq, wake;
  int          n_fail = 0, samples_checked = 0;
  always #4 mclk = ~mclk;
  dcmp_ana_model dcmp_ana_model_inst (.*);
  dcmp_top dcmp_top_inst (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk) psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1 && ++k < 9);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic t_reg;
    apb(0, 12'h000, '0);
    chk("ctrl rst", 32'h0000_0007, rd);
    apb(1, 12'h000, 32'h0000_00ff);
    apb(0, 12'h000, '0);
    chk("ctrl inv", 32'h0000_00ff, rd);
    for (int m = 0; m < 8; m++)
    begin
      apb(1, 12'h000, m);
      apb(0, 12'h000, '0);
      chk("mode", m, rd);
    end
    apb(1, 12'h000, 32'h0000_00ce);
    apb(0, 12'h000, '0);
    chk("ctrl ro", 32'h0000_000e, rd);
    chk("vneg", 2'b11, vneg_sel);
    chk("vref", 1'b1, vref_on);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_irq;
    apb(0, 12'h000, '0);
    apb(1, 12'h004, 32'h0000_000e);
    apb(0, 12'h004, '0);
    chk("irq clr", 32'h0000_000e, rd);
    vin_p[0] <= 8'h80;
    repeat (6) @(posedge mclk);
    chk("irq on", 1'b1, irq);
    apb(1, 12'h004, '0);
    apb(0, 12'h004, '0);
    chk("flag kept", 32'h0000_0001, rd);
    chk("irq off", 1'b0, irq);
    apb(0, 12'h000, '0);
    chk("cmp1", 32'h0000_004e, rd);
    apb(1, 12'h004, '0);
    apb(0, 12'h004, '0);
    chk("flag clr", '0, rd);
    apb(1, 12'h004, 32'h0000_000f);
    repeat (2) @(posedge mclk);
    chk("sw irq", 1'b1, irq);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_pin;
    apb(1, 12'h004, '0);
    apb(1, 12'h000, 32'h0000_0005);
    apb(1, 12'h00c, 32'h0000_000f);
    vin_p <= {8'h80, 8'h00};
    repeat (3) @(posedge mclk);
    chk("pin out", 2'b10, pin45_out);
    chk("pin oe", 2'b00, pin45_oe_n);
    apb(1, 12'h010, 32'h0000_000d);
    apb(0, 12'h008, '0);
    chk("port", 32'h0000_003c, rd);
    apb(0, 12'h014, '0);
    chk("unmapped", 1'b1, err);
    $display("t_pin done");
  endtask : t_pin
  task automatic t_sleep;
    apb(0, 12'h000, '0);
    apb(1, 12'h004, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("wake off", 1'b0, wake);
    vin_p[0] <= 8'h80;
    repeat (6) @(posedge mclk);
    chk("wake on", 1'b1, wake);
    chk("irq masked", 1'b0, irq);
    apb(0, 12'h000, '0);
    chk("ctrl kept", 32'h0000_00c5, rd);
    apb(1, 12'h00c, 32'h0000_003f);
    repeat (2) @(posedge mclk);
    chk("pin oe off", 2'b11, pin45_oe_n);
    apb(1, 12'h000, 32'h0000_0007);
    apb(1, 12'h004, 32'h0000_0002);
    vin_p <= '0;
    repeat (6) @(posedge mclk);
    chk("wake mode off", 1'b0, wake);
    apb(1, 12'h000, 32'h0000_0006);
    repeat (2) @(posedge mclk);
    chk("vneg low", 2'b00, vneg_sel);
    chk("vref mux", 1'b1, vref_on);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic end_of_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    #40000;
    n_fail++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    t_reg;
    t_irq;
    t_pin;
    t_sleep;
    end_of_test;
  end
endmodule : dcmp_top_tb_top
